/* txsig_pkg.sv */
// package for the transmit signaling register store
package txsig_pkg;
  localparam logic [7:0] TXSIG_BASE_ADDR  = 8'h50;  // tx_signaling_byte_01
  localparam logic [7:0] TXSIG_LAST_E1    = 8'h5f;  // tx_signaling_byte_16
  localparam logic [7:0] TXSIG_LAST_T1    = 8'h5b;  // tx_signaling_byte_12
  localparam int         TXSIG_NUM_REGS   = 16;
  localparam int         TXSIG_NUM_T1     = 12;
  localparam int         TXSIG_IDX_W      = 4;
  localparam logic [3:0] TXSIG_E1_HDR_MSK = 4'h0;   // upper nibble of first register in cas
  // timing of the host update window in d4 mode
  localparam int         TXSIG_CLK_MHZ    = 125;
  localparam int         TXSIG_D4_WIN_US  = 120;
  localparam int         TXSIG_D4_WIN_CYC = TXSIG_D4_WIN_US * TXSIG_CLK_MHZ;
  typedef enum logic [1:0] {
    TXSIG_E1_CAS,
    TXSIG_E1_CCS,
    TXSIG_T1_ESF,
    TXSIG_T1_D4
  } txsig_fmt_t;
endpackage : txsig_pkg

/* txsig_regs.sv */
// transmit signaling register store and multiframe shift loader
// Notes on behaviour
// - e1 signaling travels in time slot sixteen, cas or ccs as configured
// - plain numbering: e1 time slots 0..31 are channels 1..32
// - phone numbering: slots 1..15 are phones 1..15; slots 0, 16 unnumbered
// - phone numbering: slots 17..31 are phones 16..30
// - e1 cas: sixteen bytes at 50h..5fh; first byte upper nibble zero, low xyxx
// - e1 cas: bytes 2..16 carry abcd of two phones, even phone upper nibble
// - e1 ccs: 128 bits in order, bit 1 at msb of first byte
// - t1 esf: twelve bytes 50h..5bh, abcd for two channels, even upper
// - t1 d4: nibble holds ab then ab of next multiframe, even upper
// - copy registers into output shift register at each multiframe boundary
// - insert only when t1 or e1 enable set, per channel enable selects
// - d4 reloads every other multiframe; host writes within 120 us after
`timescale 1ns/1ps
`default_nettype none

// one register with synchronous active-low reset; every output flop of the store is one
module txsig_sync_reg
  import txsig_pkg::*;
#(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         mclk_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] val_q;

  // reset wins over the next value on the same edge
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      val_q <= RST_VAL;
    end else begin
      val_q <= d_in;
    end
  end

  assign q_out = val_q;

endmodule : txsig_sync_reg

// sixteen host bytes, copied as one image into the framer on accepted boundaries
module txsig_regs
  import txsig_pkg::*;
#(
  parameter int D4_WIN_CYC = TXSIG_D4_WIN_CYC
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_b_in,
  // host parallel port, same clock domain
  input  wire logic [7:0]       host_addr_in,
  input  wire logic [7:0]       host_wdata_in,
  input  wire logic             host_wr_in,
  input  wire logic             host_rd_in,
  output logic [7:0]            host_rdata_out,
  output logic                  host_rdata_valid_out,
  // framing configuration
  input  wire txsig_fmt_t       fmt_in,
  input  wire logic             t1_tx_sig_insert_enable_in,
  input  wire logic             e1_tx_sig_insert_enable_in,
  input  wire logic [31:0]      per_channel_sw_sig_insert_enable_in,
  // framer side
  input  wire logic             mf_boundary_in,
  output logic [127:0]          tx_sig_shift_out,
  output logic                  tx_sig_load_out,
  output logic [31:0]           tx_sig_chan_insert_out,
  output logic                  d4_update_window_out
);

  // sizes and positions; kept local so that no bare figure sits in the logic
  localparam int                     BYTE_W     = 8;
  localparam int                     NIB_W      = 4;
  localparam int                     SHIFT_W    = TXSIG_NUM_REGS * BYTE_W;
  localparam int                     SLOT_N     = 32;
  localparam int                     SLOT_FRAME = 0;   // e1 alignment slot
  localparam int                     SLOT_SIG   = 16;  // the e1 signaling slot itself
  localparam int                     CNT_W      = $clog2(D4_WIN_CYC + 1);
  localparam logic [TXSIG_IDX_W-1:0] HDR_IDX    = '0;  // the cas header byte

  // alternate-boundary tracker for d4; other formats keep it parked on load
  typedef enum logic {
    TXSIG_D4_LOAD_NEXT,
    TXSIG_D4_SKIP_NEXT
  } txsig_d4_state_t;

  // signaling store; no reset since the contents are unspecified until written
  logic [BYTE_W-1:0]      sig_mem_q [TXSIG_NUM_REGS];

  // registers behind the outputs, each with its next value
  logic [SHIFT_W-1:0]     shift_q;
  logic [SHIFT_W-1:0]     shift_d;
  logic                   load_q;
  logic                   load_d;
  logic [SLOT_N-1:0]      ins_q;
  logic [SLOT_N-1:0]      ins_d;
  logic [BYTE_W-1:0]      rdata_q;
  logic [BYTE_W-1:0]      rdata_d;
  logic                   rvalid_q;
  logic                   rvalid_d;
  txsig_d4_state_t        d4_state_q;
  txsig_d4_state_t        d4_state_d;
  logic                   win_q;
  logic                   win_d;
  logic [CNT_W-1:0]       win_cnt_q;
  logic [CNT_W-1:0]       win_cnt_d;
  // flattened image of the store, rebuilt every cycle
  logic [SHIFT_W-1:0]     img;

  // format decode
  wire                    is_e1      = (fmt_in == TXSIG_E1_CAS) || (fmt_in == TXSIG_E1_CCS);
  wire                    is_cas     = (fmt_in == TXSIG_E1_CAS);
  wire                    is_d4      = (fmt_in == TXSIG_T1_D4);

  // address decode; t1 formats answer only on the first twelve bytes
  wire [BYTE_W-1:0]       last_addr  = is_e1 ? TXSIG_LAST_E1 : TXSIG_LAST_T1;
  wire                    above_base = (host_addr_in >= TXSIG_BASE_ADDR);
  wire                    below_last = (host_addr_in <= last_addr);
  wire                    addr_hit   = above_base && below_last;
  wire [BYTE_W-1:0]       addr_off   = host_addr_in - TXSIG_BASE_ADDR;
  wire [TXSIG_IDX_W-1:0]  idx        = addr_off[TXSIG_IDX_W-1:0];
  wire                    wr_hit     = host_wr_in && addr_hit;
  wire                    rd_hit     = host_rd_in && addr_hit;

  // the cas header byte keeps its upper nibble at zero whatever the host writes
  wire                    cas_hdr    = is_cas && (idx == HDR_IDX);
  wire [NIB_W-1:0]        wr_low_nib = host_wdata_in[NIB_W-1:0];
  wire [BYTE_W-1:0]       hdr_byte   = {TXSIG_E1_HDR_MSK, wr_low_nib};
  wire [BYTE_W-1:0]       wdata_eff  = cas_hdr ? hdr_byte : host_wdata_in;

  // read answer: stored byte inside the range of the format, zero elsewhere
  wire [BYTE_W-1:0]       rd_byte    = sig_mem_q[idx];
  assign rdata_d  = rd_hit ? rd_byte : '0;
  assign rvalid_d = host_rd_in;

  // insertion enable: the mode bit first, then the per channel select
  wire                    ins_en     = is_e1 ? e1_tx_sig_insert_enable_in
                                             : t1_tx_sig_insert_enable_in;
  // slots 0 and 16 carry no phone channel in e1, so they never take register signaling
  wire [SLOT_N-1:0]       one_slot   = SLOT_N'(1);
  wire [SLOT_N-1:0]       e1_unused  = (one_slot << SLOT_FRAME) | (one_slot << SLOT_SIG);
  wire [SLOT_N-1:0]       slot_keep  = is_e1 ? ~e1_unused : '1;
  wire [SLOT_N-1:0]       sw_sel     = per_channel_sw_sig_insert_enable_in & slot_keep;
  assign ins_d = ins_en ? sw_sel : '0;

  // d4 reloads only on alternate boundaries; every other format loads on each one
  wire                    d4_may_load = (d4_state_q == TXSIG_D4_LOAD_NEXT);
  wire                    do_load     = mf_boundary_in && (!is_d4 || d4_may_load);
  assign load_d  = do_load;
  assign shift_d = do_load ? img : shift_q;

  // image layout, byte 1 at the top down to byte 16 at the bottom:
  //   e1 cas: byte 1 is the header, bytes 2..16 hold phones 1..30 as abcd nibbles
  //   e1 ccs: the 128 message bits in order, with no nibble structure
  //   t1 esf: bytes 1..12 hold channels 1..24 as abcd nibbles, bytes 13..16 zero
  //   t1 d4 : bytes 1..12 hold ab of this multiframe, then ab of the next
  // the store already holds that order, so the copy is a straight move per byte;
  // bytes the t1 formats leave unused are zeroed so stale e1 data never leaks out
  always_comb begin
    img = '0;
    for (int i = 0; i < TXSIG_NUM_REGS; i++) begin
      if (is_e1 || (i < TXSIG_NUM_T1)) begin
        img[SHIFT_W-1-BYTE_W*i -: BYTE_W] = sig_mem_q[i];
      end
    end
  end

  // next d4 phase; a boundary in any other format parks the tracker on load
  always_comb begin
    d4_state_d = d4_state_q;
    case (d4_state_q)
      TXSIG_D4_LOAD_NEXT: begin
        if (mf_boundary_in && is_d4) begin
          d4_state_d = TXSIG_D4_SKIP_NEXT;
        end
      end
      TXSIG_D4_SKIP_NEXT: begin
        if (mf_boundary_in) begin
          d4_state_d = TXSIG_D4_LOAD_NEXT;
        end
      end
      default: begin
        d4_state_d = TXSIG_D4_LOAD_NEXT;
      end
    endcase
  end

  // host update window after a d4 reload; advisory only, late writes are not refused
  wire                    win_start  = is_d4 && do_load;
  wire                    cnt_busy   = (win_cnt_q != '0);
  wire [CNT_W-1:0]        win_len    = CNT_W'(D4_WIN_CYC - 1);
  wire [CNT_W-1:0]        cnt_dec    = win_cnt_q - 1'b1;
  assign win_cnt_d = win_start ? win_len : (cnt_busy ? cnt_dec : win_cnt_q);
  assign win_d     = win_start || (cnt_busy && win_q);

  // host writes land one edge after the strobe; a read in that cycle sees the old byte
  always_ff @(posedge mclk_in) begin
    if (wr_hit) begin
      sig_mem_q[idx] <= wdata_eff;
    end
  end

  // read data, valid for the one cycle after the read strobe
  txsig_sync_reg #(
    .W (BYTE_W)
  ) u_rdata_reg (
    .mclk_in  (mclk_in),
    .rst_b_in (rst_b_in),
    .d_in     (rdata_d),
    .q_out    (rdata_q)
  );

  // read valid pulse
  txsig_sync_reg #(
    .W (1)
  ) u_rvalid_reg (
    .mclk_in  (mclk_in),
    .rst_b_in (rst_b_in),
    .d_in     (rvalid_d),
    .q_out    (rvalid_q)
  );

  // image held for the framer until the next accepted boundary
  txsig_sync_reg #(
    .W (SHIFT_W)
  ) u_shift_reg (
    .mclk_in  (mclk_in),
    .rst_b_in (rst_b_in),
    .d_in     (shift_d),
    .q_out    (shift_q)
  );

  // load pulse, on the same edge as the image changes
  txsig_sync_reg #(
    .W (1)
  ) u_load_reg (
    .mclk_in  (mclk_in),
    .rst_b_in (rst_b_in),
    .d_in     (load_d),
    .q_out    (load_q)
  );

  // insertion mask, one cycle behind its inputs
  txsig_sync_reg #(
    .W (SLOT_N)
  ) u_ins_reg (
    .mclk_in  (mclk_in),
    .rst_b_in (rst_b_in),
    .d_in     (ins_d),
    .q_out    (ins_q)
  );

  // window flag
  txsig_sync_reg #(
    .W (1)
  ) u_win_reg (
    .mclk_in  (mclk_in),
    .rst_b_in (rst_b_in),
    .d_in     (win_d),
    .q_out    (win_q)
  );

  // window length counter, sized from the parameter so a longer window never wraps
  txsig_sync_reg #(
    .W (CNT_W)
  ) u_win_cnt_reg (
    .mclk_in  (mclk_in),
    .rst_b_in (rst_b_in),
    .d_in     (win_cnt_d),
    .q_out    (win_cnt_q)
  );

  // d4 phase; after reset the first d4 boundary loads
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      d4_state_q <= TXSIG_D4_LOAD_NEXT;
    end else begin
      d4_state_q <= d4_state_d;
    end
  end

  // every output comes straight from a flop
  assign host_rdata_out         = rdata_q;
  assign host_rdata_valid_out   = rvalid_q;
  assign tx_sig_shift_out       = shift_q;
  assign tx_sig_load_out        = load_q;
  assign tx_sig_chan_insert_out = ins_q;
  assign d4_update_window_out   = win_q;

endmodule : txsig_regs
`default_nettype wire

/* txsig_sva.sv */
// port assertions for the transmit signaling store
`timescale 1ns/1ps
`default_nettype none
module txsig_sva
  import txsig_pkg::*;
(
  input wire logic         mclk_in,
  input wire logic         rst_b_in,
  input wire logic         host_rd_in,
  input wire logic         host_rdata_valid_out,
  input wire txsig_fmt_t   fmt_in,
  input wire logic         mf_boundary_in,
  input wire logic         tx_sig_load_out,
  input wire logic [127:0] tx_sig_shift_out,
  input wire logic [31:0]  tx_sig_chan_insert_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  a_rd_answer: assert property (host_rd_in |=> host_rdata_valid_out) else $error("no valid");
  a_rd_quiet: assert property (!host_rd_in |=> !host_rdata_valid_out) else $error("stray");
  a_load_cause: assert property (tx_sig_load_out |-> $past(mf_boundary_in)) else $error("ld");
  a_load_taken: assert property (mf_boundary_in && fmt_in != TXSIG_T1_D4 |=> tx_sig_load_out)
    else $error("no load");
  // a fresh reset may clear the image, so the hold is only judged a cycle later
  a_shift_hold: assert property ($past(rst_b_in) && !tx_sig_load_out |-> $stable(tx_sig_shift_out))
    else $error("image moved");
  a_cas_header: assert property (tx_sig_load_out && fmt_in == TXSIG_E1_CAS
    |-> tx_sig_shift_out[127:124] == 4'h0) else $error("header");
  a_t1_tail: assert property (tx_sig_load_out && fmt_in[1] |-> tx_sig_shift_out[31:0] == 32'h0)
    else $error("tail");
  a_e1_slots: assert property (!fmt_in[1] |=> !tx_sig_chan_insert_out[0]
    && !tx_sig_chan_insert_out[16]) else $error("slot 0/16");
endmodule : txsig_sva
bind txsig_regs txsig_sva u_sva (.*);
`default_nettype wire

/* txsig_host.sv */
// host processor model on the register port
`timescale 1ns/1ps
`default_nettype none
module txsig_host (
  input  wire logic       clk_in,
  output logic [7:0]      addr_out,
  output logic [7:0]      wdata_out,
  output logic            wr_out,
  output logic            rd_out,
  input  wire logic [7:0] rdata_in
);
  initial {addr_out, wdata_out, wr_out, rd_out} = 18'h0;
  // one-cycle strobe; read data taken while valid stands
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge clk_in) {wr_out, rd_out, addr_out, wdata_out} = {w, !w, a, d};
    @(negedge clk_in) q = rdata_in;
    {wr_out, rd_out} = 2'b00;
    wdata_out = ~d; // released data bus must not keep its last value
  endtask : xfer
endmodule : txsig_host
`default_nettype wire

/* tb.sv */
// self-checking bench for the transmit signaling store
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end
module tb;
  import txsig_pkg::*;
  logic         mclk_in = 0, rst_b_in = 0, mf = 0, t1en = 0, e1en = 0, wr, rd, vld, ld, win;
  logic [7:0]   addr, wd, rdat, q, mem[16];
  logic [31:0]  pce = 0, ins;
  logic [127:0] img, shf;
  txsig_fmt_t   fmt = TXSIG_E1_CAS;
  int           n_mismatch = 0, total_checks = 0;
  txsig_host h (.clk_in(mclk_in), .addr_out(addr), .wdata_out(wd), .wr_out(wr), .rd_out(rd),
    .rdata_in(rdat));
  txsig_regs #(.D4_WIN_CYC(20)) DUT (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .host_addr_in(addr), .host_wdata_in(wd), .host_wr_in(wr), .host_rd_in(rd),
    .host_rdata_out(rdat), .host_rdata_valid_out(vld), .fmt_in(fmt),
    .t1_tx_sig_insert_enable_in(t1en), .e1_tx_sig_insert_enable_in(e1en),
    .per_channel_sw_sig_insert_enable_in(pce), .mf_boundary_in(mf), .tx_sig_shift_out(shf),
    .tx_sig_load_out(ld), .tx_sig_chan_insert_out(ins), .d4_update_window_out(win));
  initial forever #4 mclk_in = ~mclk_in;
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  // watchdog well beyond the roughly 500 cycles the run needs
  initial begin
    #100000 n_mismatch++;
    print_verdict();
  end
  // each format: write all sixteen bytes (t1 keeps only the first twelve), read back, then two boundaries
  initial begin
    void'($urandom(32'hf8c2));
    repeat (10) @(negedge mclk_in);
    `CHK("reset shift", 128'h0, shf)
    `CHK("reset load", 1'b0, ld)
    `CHK("reset insert", 32'h0, ins)
    `CHK("reset window", 1'b0, win)
    `CHK("reset valid", 1'b0, vld)
    rst_b_in = 1;
    for (int f = 0; f < 4; f++) begin
      @(negedge mclk_in) fmt = txsig_fmt_t'(f);
      {pce, t1en, e1en} = {$urandom, 2'($urandom)};
      for (int i = 0; i < 16; i++) begin
        mem[i] = 8'($urandom);
        h.xfer(1, 8'h50 + 8'(i), mem[i], q);
      end
      for (int i = 0; i < 16; i++) begin
        if (f > 1 && i > 11) mem[i] = 8'h00;
        if (f == 0 && i == 0) mem[i][7:4] = 4'h0;
        img[127 - 8 * i -: 8] = mem[i];
        h.xfer(0, 8'h50 + 8'(i), 8'h00, q);
        `CHK("rdata", mem[i], q)
        `CHK("valid", 1'b1, vld)
      end
      h.xfer(0, 8'h4f, 8'h00, q);
      `CHK("unmapped", 8'h00, q)
      for (int b = 0; b < 2; b++) begin
        @(negedge mclk_in) mf = 1;
        @(negedge mclk_in) mf = 0;
        `CHK("load", 1'(f != 3 || b == 0), ld)
        `CHK("shift", img, shf)
        `CHK("window", 1'(f == 3 && b == 0), win)
        `CHK("insert", pce & {32{f < 2 ? e1en : t1en}} & (f < 2 ? 32'hfffefffe : '1), ins)
        repeat (25) @(negedge mclk_in);
      end
    end
    print_verdict();
  end
endmodule : tb
`default_nettype wire
